// ==== dv/voltage_sensor_core_access_bench.sv ====
// Purpose: self-checking bench for the voltage sensor access block
// Assumes: short conversion count keeps the run brief
// Notes: inputs change on the falling clock edge
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
   $display("[ERR] %0t got %0h want %0h", $time, (a), (b)); end end
module voltage_sensor_core_access_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import vsc_pkg::*;
   localparam int     CC = 3;
   logic              clk        = 1'b0;
   logic              reset      = 1'b1;
   logic              access_en  = 1'b0;
   logic              res_ready  = 1'b1;
   logic [RES_W-1:0]  sample_in  = 6'h00;
   logic [RES_W-1:0]  cal_offset = 6'h00;
   logic              shift_en, setup_din, conv_done, seq_done, res_valid;
   logic [CHAN_W-1:0] chan_pick, active_chan;
   logic [DOUT_W-1:0] result;
   logic [RES_W-1:0]  res_data;
   int                n_errors   = 0;
   int                num_checks = 0;
   // 25 MHz stand-in; the real sensor is limited to 11 MHz
   initial begin
      forever #20 clk = ~clk;
   end
   vsc_core #(.CONV_CYCLES(CC)) vsc_core_i (.CLK(clk), .RESET(reset), .ACCESS_EN(access_en),
      .SHIFT_EN(shift_en), .SETUP_DIN(setup_din), .CHAN_PICK(chan_pick), .SAMPLE_IN(sample_in),
      .CAL_OFFSET(cal_offset), .CONV_DONE(conv_done), .SEQ_DONE(seq_done), .RESULT(result),
      .ACTIVE_CHAN(active_chan), .RES_VALID(res_valid), .RES_READY(res_ready),
      .RES_DATA(res_data));
   vsc_ctrl_model vsc_ctrl_model_i (.CLK(clk), .shift_en(shift_en), .setup_din(setup_din),
      .chan_pick(chan_pick), .conv_done(conv_done), .result(result));
   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run
   // enable first, hold reset, then two idle clocks
   task automatic restart();
      @(negedge clk);
      access_en = 1'b1;
      reset     = 1'b1;
      repeat (6) @(negedge clk);
      `CHK({conv_done, seq_done, res_valid, result}, 15'h0000)
      reset = 1'b0;
      repeat (2) @(negedge clk);
   endtask : restart
   task automatic count_done(input int n, output int hits);
      hits = 0;
      repeat (n) begin
         @(negedge clk);
         hits += int'(conv_done === 1'b1);
      end
   endtask : count_done
   // bounded wait for the next done strobe; the active channel moves on with
   // the strobe, so the closed channel is the one seen just before it
   task automatic wait_done(output logic [CHAN_W-1:0] ch_done);
      int k;
      k       = 0;
      ch_done = active_chan;
      @(negedge clk);
      while (conv_done !== 1'b1 && k < 200) begin
         ch_done = active_chan;
         @(negedge clk);
         k++;
      end
      `CHK(k < 200, 1'b1)
   endtask : wait_done
   task automatic check_conv(input logic [CHAN_W-1:0] ch, input logic last,
                             input logic [RES_W-1:0] code);
      logic [CHAN_W-1:0] seen;
      wait_done(seen);
      `CHK(seen, ch)
      `CHK(seq_done, last)
      `CHK(result, {code, 6'h00})
   endtask : check_conv
   // each automatic mode, one pass and a restart of it
   task automatic test_modes();
      logic [1:0] md;
      logic [3:0] first, last;
      for (int m = 0; m < 3; m++) begin
         md        = 2'(m);
         first     = (md == 2'h0) ? 4'h2 : 4'h0;
         last      = (md == 2'h2) ? 4'h1 : 4'h7;
         sample_in = 6'h2A + 6'(m);
         restart();
         vsc_ctrl_model_i.configure({6'h00, md}, 4'h0);
         for (logic [3:0] c = first; c <= last; c++) begin
            check_conv(c, c == last, sample_in);
         end
         check_conv(first, first == last, sample_in);
      end
   endtask : test_modes
   // next manual channel given well before the strobe
   task automatic test_manual();
      sample_in = 6'h15;
      restart();
      vsc_ctrl_model_i.configure(8'h03, 4'h5);
      vsc_ctrl_model_i.set_chan(4'h6);
      check_conv(4'h5, 1'b1, 6'h15);
      sample_in = 6'h16;
      check_conv(4'h6, 1'b1, 6'h16);
      repeat (2) @(negedge clk);
      `CHK(vsc_ctrl_model_i.cap_data, 6'h16)
   endtask : test_manual
   // offset joins only with calibration on; rewrite after a sequence
   task automatic test_cal();
      sample_in  = 6'h20;
      cal_offset = 6'h05;
      restart();
      vsc_ctrl_model_i.configure(8'h43, 4'h2);
      check_conv(4'h2, 1'b1, 6'h25);
      vsc_ctrl_model_i.configure(8'h03, 4'h3);
      check_conv(4'h3, 1'b1, 6'h20);
      cal_offset = 6'h00;
   endtask : test_cal
   // access dropped mid-run clears state and silences strobes
   task automatic test_disabled();
      int                hits;
      logic [CHAN_W-1:0] seen;
      restart();
      vsc_ctrl_model_i.configure(8'h01, 4'h0);
      wait_done(seen);
      access_en = 1'b0;
      count_done(40, hits);
      `CHK(hits, 0)
      `CHK({res_valid, result, active_chan}, 17'h00000)
   endtask : test_disabled
   // two words fill the buffer, then conversion must stall
   task automatic test_buffer();
      int                hits;
      logic [CHAN_W-1:0] seen;
      restart();
      res_ready = 1'b0;
      sample_in = 6'h11;
      vsc_ctrl_model_i.configure(8'h01, 4'h0);
      wait_done(seen);
      `CHK(seen, 4'h0)
      sample_in = 6'h22;
      wait_done(seen);
      `CHK(seen, 4'h1)
      count_done(30, hits);
      `CHK(hits, 0)
      `CHK(res_valid, 1'b1)
      res_ready = 1'b1;
      `CHK(res_data, 6'h11)
      @(negedge clk);
      `CHK(res_data, 6'h22)
   endtask : test_buffer
   initial begin
      test_modes();
      test_manual();
      test_cal();
      test_disabled();
      test_buffer();
      complete_run();
   end
   // watchdog well past the expected run length
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      complete_run();
   end
endmodule : voltage_sensor_core_access_bench
`default_nettype wire

// ==== dv/vsc_ctrl_model.sv ====
// Purpose: fabric controller stand-in driving the sensor access block
// Assumes: drives its outputs on the falling clock edge
// Notes: captures each code when the done strobe falls
`default_nettype none
module vsc_ctrl_model
   import vsc_pkg::*;
(
   // clock
   input  wire logic                       CLK,
   // control towards the block
   output logic                            shift_en,
   output logic                            setup_din,
   output logic [vsc_pkg::CHAN_W-1:0]      chan_pick,
   // results from the block
   input  wire logic                       conv_done,
   input  wire logic [vsc_pkg::DOUT_W-1:0] result
);
   timeunit 1ns;
   timeprecision 1ps;
   logic             prev_ff  = 1'b0;
   logic [RES_W-1:0] cap_data = 6'h00;
   int               cap_n    = 0;
   initial begin
      shift_en  = 1'b0;
      setup_din = 1'b0;
      chan_pick = 4'h0;
   end
   // eight bits lsb first, channel set beforehand
   task automatic configure(input logic [SETUP_W-1:0] word, input logic [CHAN_W-1:0] ch);
      chan_pick = ch;
      for (int i = 0; i < SETUP_W; i++) begin
         @(negedge CLK);
         shift_en  = 1'b1;
         setup_din = word[i];
      end
      @(negedge CLK);
      shift_en  = 1'b0;
      setup_din = ~word[SETUP_W-1];  // stale bit must not look valid
   endtask : configure
   // next manual channel, 0..7 only, set off the edge
   task automatic set_chan(input logic [CHAN_W-1:0] ch);
      @(negedge CLK);
      chan_pick = ch;
   endtask : set_chan
   // take the code on the falling strobe, not the rising one
   always @(posedge CLK) begin
      prev_ff <= conv_done;
      if (prev_ff && !conv_done) begin
         cap_data <= result[DOUT_W-1:RES_LSB];
         cap_n    <= cap_n + 1;
      end
   end
endmodule : vsc_ctrl_model
`default_nettype wire

// ==== src/vsc_core.sv ====
// Purpose: fabric-side voltage sensor access: setup shift, sequencer, results
// Assumes: controller keeps the access protocol; analog path is a stand-in
// Notes: the converted code comes in on SAMPLE_IN from the analog model
`default_nettype none
module vsc_core
   import vsc_pkg::*;
#(
   parameter int CONV_CYCLES = CONV_CYC
) (
   // clock and reset
   input  wire logic                      CLK,
   input  wire logic                      RESET,
   // fabric control
   input  wire logic                      ACCESS_EN,
   input  wire logic                      SHIFT_EN,
   input  wire logic                      SETUP_DIN,
   input  wire logic [vsc_pkg::CHAN_W-1:0] CHAN_PICK,
   // analog stand-in
   input  wire logic [vsc_pkg::RES_W-1:0]  SAMPLE_IN,
   input  wire logic [vsc_pkg::RES_W-1:0]  CAL_OFFSET,
   // results
   output logic                           CONV_DONE,
   output logic                           SEQ_DONE,
   output logic [vsc_pkg::DOUT_W-1:0]     RESULT,
   output logic [vsc_pkg::CHAN_W-1:0]     ACTIVE_CHAN,
   // buffered result stream
   output logic                           RES_VALID,
   input  wire logic                      RES_READY,
   output logic [vsc_pkg::RES_W-1:0]      RES_DATA
);
   import vsc_pkg::*;

   localparam int CW = $clog2(CONV_CYCLES + 1);

   logic [SETUP_W-1:0] sensor_setup_word_ff, nxt_setup;
   logic               shift_d_ff, nxt_shift_d;
   vsc_state_t         state_ff, nxt_state;
   logic [CHAN_W-1:0]  chan_ff, nxt_chan;
   logic [CW-1:0]      cnt_ff, nxt_cnt;
   logic               eoc_ff, nxt_eoc, eos_ff, nxt_eos;
   logic [DOUT_W-1:0]  res_ff, nxt_res;
   logic [1:0]         sequencer_select;
   logic               sequencer_select_lo, sequencer_select_hi;
   logic               ch0_polarity, ch1_polarity, cal_en;
   logic               run, start, last_chan, buf_ready;
   logic [CHAN_W-1:0]  first_chan, end_chan;
   logic [RES_W-1:0]   code;

   // setup word fields
   assign sequencer_select    = sensor_setup_word_ff[MODE_LSB +: 2];
   assign sequencer_select_lo = sequencer_select[0];
   assign sequencer_select_hi = sequencer_select[1];
   assign ch0_polarity        = sensor_setup_word_ff[POL0_BIT];
   assign ch1_polarity        = sensor_setup_word_ff[POL1_BIT];
   assign cal_en              = sensor_setup_word_ff[CAL_BIT];

   // [RQ4] access enable gate
   // [RQ2] reset stops conversion clock
   assign run = ACCESS_EN && !RESET;
   // [RQ15] start on shift fall
   assign start = shift_d_ff && !SHIFT_EN && run;

   // [RQ11] sequence range decode
   always_comb begin
      case ({sequencer_select_hi, sequencer_select_lo})
         MODE_HI_SIX: begin
            first_chan = CH_FIRST_HI;
            end_chan   = CH_LAST;
         end
         MODE_ALL: begin
            first_chan = CH_FIRST_ALL;
            end_chan   = CH_LAST;
         end
         MODE_LO_TWO: begin
            first_chan = CH_FIRST_ALL;
            end_chan   = CH_LAST_LO;
         end
         default: begin
            first_chan = CHAN_PICK;
            end_chan   = CHAN_PICK;
         end
      endcase
   end
   // manual mode: every channel is its own one-channel sequence, so the
   // pick input may already name the next channel without hiding the end
   assign last_chan = (sequencer_select == MODE_MANUAL) || (chan_ff == end_chan);

   // [RQ13] calibration adds the offset; polarity bits only affect the analog side
   assign code = cal_en ? RES_W'(SAMPLE_IN + CAL_OFFSET) : SAMPLE_IN;

   // [RQ5] lsb-first serial setup load
   always_comb begin
      nxt_setup   = sensor_setup_word_ff;
      nxt_shift_d = run ? SHIFT_EN : 1'b0;
      if (run && SHIFT_EN) begin
         nxt_setup = {SETUP_DIN, sensor_setup_word_ff[SETUP_W-1:1]};
      end
   end

   // conversion sequencer; stalls at done when result buffer is full
   always_comb begin
      nxt_state = state_ff;
      nxt_chan  = chan_ff;
      nxt_cnt   = cnt_ff;
      nxt_eoc   = 1'b0;
      nxt_eos   = 1'b0;
      nxt_res   = res_ff;
      case (state_ff)
         ST_IDLE: begin
            if (start) begin
               nxt_state = ST_CONV;
               nxt_chan  = first_chan;
               nxt_cnt   = '0;
            end
         end
         ST_CONV: begin
            if (SHIFT_EN) begin
               nxt_state = ST_IDLE;
            end else if (cnt_ff == CW'(CONV_CYCLES - 1)) begin
               nxt_state = ST_DONE;
            end else begin
               nxt_cnt = cnt_ff + CW'(1);
            end
         end
         ST_DONE: begin
            if (buf_ready) begin
               // [RQ8] per channel done
               nxt_eoc   = 1'b1;
               // [RQ9] sequence done with last
               nxt_eos   = last_chan;
               // [RQ21] six-bit code placement
               nxt_res   = {code, {RES_LSB{1'b0}}};
               nxt_cnt   = '0;
               nxt_state = ST_CONV;
               // [RQ19] wrap and repeat
               nxt_chan  = last_chan ? first_chan :
                           (sequencer_select == MODE_MANUAL ? CHAN_PICK : chan_ff + 4'h1);
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // register update; reset or disabled access clears everything
   always_ff @(posedge CLK) begin
      if (RESET || !ACCESS_EN) begin
         sensor_setup_word_ff <= SETUP_RST;
         shift_d_ff           <= 1'b0;
         state_ff             <= ST_IDLE;
         chan_ff              <= CH_RST;
         cnt_ff               <= '0;
         eoc_ff               <= 1'b0;
         eos_ff               <= 1'b0;
         res_ff               <= '0;
      end else begin
         sensor_setup_word_ff <= nxt_setup;
         shift_d_ff           <= nxt_shift_d;
         state_ff             <= nxt_state;
         chan_ff              <= nxt_chan;
         cnt_ff               <= nxt_cnt;
         eoc_ff               <= nxt_eoc;
         eos_ff               <= nxt_eos;
         res_ff               <= nxt_res;
      end
   end

   assign CONV_DONE   = eoc_ff;
   assign SEQ_DONE    = eos_ff;
   assign RESULT      = res_ff;
   assign ACTIVE_CHAN = chan_ff;

   // result buffer so a slow reader loses no word
   vsc_skid #(.W(RES_W)) u_buf (
      .clk       (CLK),
      .rst       (RESET || !ACCESS_EN),
      .in_valid  (state_ff == ST_DONE),
      .in_ready  (buf_ready),
      .in_data   (code),
      .out_valid (RES_VALID),
      .out_ready (RES_READY),
      .out_data  (RES_DATA)
   );

   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);

   // [RQ2] reset clears strobes
   reset_clears_a: assert property ($fell(RESET) |-> // [RQ2]
         !CONV_DONE && !SEQ_DONE && RESULT == '0)
      else $error("strobe or result left after reset");
   seq_with_eoc_a: assert property (SEQ_DONE |-> CONV_DONE) // [RQ9]
      else $error("sequence done without conversion done");
   eoc_pulse_a: assert property (CONV_DONE |=> !CONV_DONE) // [RQ8]
      else $error("conversion done longer than one cycle");
   start_conv_a: assert property (start |=> state_ff == ST_CONV) // [RQ15]
      else $error("no start on shift fall");
   gate_off_a: assert property (!ACCESS_EN |=> state_ff == ST_IDLE) // [RQ4]
      else $error("sequencer ran while disabled");
   shift_lsb_a: assert property (run && SHIFT_EN |=> // [RQ5]
         sensor_setup_word_ff[SETUP_W-1] == $past(SETUP_DIN))
      else $error("serial bit not shifted in");
   res_low_a: assert property (CONV_DONE |-> RESULT[RES_LSB-1:0] == '0) // [RQ21]
      else $error("reserved result bits set");
   wrap_seq_a: assert property (SEQ_DONE && sequencer_select != MODE_MANUAL && run // [RQ19]
         |-> chan_ff == first_chan)
      else $error("sequence did not wrap");
   range_a: assert property (state_ff == ST_CONV && sequencer_select == MODE_LO_TWO // [RQ11]
         |-> chan_ff <= CH_LAST_LO)
      else $error("channel outside two-channel range");
   chan_step_a: assert property (CONV_DONE && !SEQ_DONE // [RQ11]
         && sequencer_select != MODE_MANUAL |-> chan_ff == $past(chan_ff) + 4'h1)
      else $error("channel sequence skipped a step");
   manual_seq_a: assert property (CONV_DONE && sequencer_select == MODE_MANUAL |-> SEQ_DONE) // [RQ9]
      else $error("manual conversion without sequence done");
   cal_off_a: assert property (CONV_DONE && !$past(cal_en) // [RQ13]
         |-> RESULT[DOUT_W-1:RES_LSB] == $past(SAMPLE_IN))
      else $error("calibration offset applied while off");

   cov_start_c: cover property (start);
   cov_seq_c: cover property (SEQ_DONE);
   cov_stall_c: cover property (state_ff == ST_DONE && !buf_ready);
   cov_manual_c: cover property (CONV_DONE && sequencer_select == MODE_MANUAL);
   cov_cal_c: cover property (CONV_DONE && cal_en);
endmodule : vsc_core
`default_nettype wire

// ==== src/vsc_pkg.sv ====
// Purpose: shared constants for the voltage sensor core access block
// Assumes: one fabric clock, synchronous active-high reset
// Notes: conversion timing is modelled, not taken from silicon
// Contract
// [RQ1] controller clocks sensor at most 11 MHz; the bench clock runs at 25 MHz
// [RQ2] reset clears registers, stops conversion clock
// [RQ3] conversion begins only after reset falls
// [RQ4] access enable gates all sensor activity
// [RQ5] 8-bit setup word shifted LSB first
// [RQ6] shift enable held exactly eight cycles
// [RQ7] controller gives 4-bit channel in manual
// [RQ8] conversion done pulses after each channel
// [RQ9] sequence done coincides with last conversion done
// [RQ10] controller captures result bits 11:6 on fall
// [RQ11] setup bits 1:0 select channel sequence
// [RQ12] controller writes polarity bits as zero
// [RQ13] setup bit 6 enables calibration
// [RQ14] controller waits two clocks between setup steps
// [RQ15] conversion starts when shift enable falls
// [RQ16] first manual channel stable before start
// [RQ17] next manual channel one clock early
// [RQ18] reconfigure only after sequence done pulse
// [RQ19] sequence repeats while enabled and out of reset
// [RQ20] new sequence repeats procedure from reset
// [RQ21] each result is a 6-bit code
// [RQ22] controller idles while reset or disabled
// [RQ23] manual channel numbers restricted to 0..7
`default_nettype none
package vsc_pkg;
   localparam int          SETUP_W      = 8;
   localparam int          CHAN_W       = 4;
   localparam int          RES_W        = 6;
   localparam int          DOUT_W       = 12;
   localparam int          RES_LSB      = 6;
   localparam int          MODE_LSB     = 0;
   localparam int          POL0_BIT     = 2;
   localparam int          POL1_BIT     = 3;
   localparam int          CAL_BIT      = 6;
   localparam logic [1:0]  MODE_HI_SIX  = 2'h0;
   localparam logic [1:0]  MODE_ALL     = 2'h1;
   localparam logic [1:0]  MODE_LO_TWO  = 2'h2;
   localparam logic [1:0]  MODE_MANUAL  = 2'h3;
   localparam logic [3:0]  CH_FIRST_HI  = 4'h2;
   localparam logic [3:0]  CH_FIRST_ALL = 4'h0;
   localparam logic [3:0]  CH_LAST_LO   = 4'h1;
   localparam logic [3:0]  CH_LAST      = 4'h7;
   localparam logic [7:0]  SETUP_RST    = 8'h00;
   localparam logic [3:0]  CH_RST       = 4'h0;
   localparam int          CONV_CYC     = 20;
   localparam real         CLK_MHZ      = 25.0;
   localparam real         CLK_MAX_MHZ  = 11.0;
   typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_DONE} vsc_state_t;
endpackage : vsc_pkg
`default_nettype wire

// ==== src/vsc_skid.sv ====
// Purpose: two-entry buffer for result words
// Assumes: same clock on both sides
// Notes: full only when both entries hold data
`default_nettype none
module vsc_skid #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   logic [W-1:0] mem_ff [2];
   logic [W-1:0] nxt_mem [2];
   logic         rd_ff, wr_ff, nxt_rd, nxt_wr;
   logic [1:0]   cnt_ff, nxt_cnt;
   logic         push, pop;

   // occupancy bookkeeping; ready drops only when both slots are full
   always_comb begin
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      in_ready  = (cnt_ff != 2'h2);
      out_valid = (cnt_ff != 2'h0);
      out_data  = mem_ff[rd_ff];
      nxt_mem   = mem_ff;
      nxt_wr    = wr_ff;
      nxt_rd    = rd_ff;
      nxt_cnt   = cnt_ff;
      if (push) begin
         nxt_mem[wr_ff] = in_data;
         nxt_wr         = ~wr_ff;
      end
      if (pop) begin
         nxt_rd = ~rd_ff;
      end
      nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
   end

   // storage registers
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_ff  <= 1'b0;
         wr_ff  <= 1'b0;
         cnt_ff <= 2'h0;
      end else begin
         rd_ff  <= nxt_rd;
         wr_ff  <= nxt_wr;
         cnt_ff <= nxt_cnt;
      end
      mem_ff <= nxt_mem;
   end
endmodule : vsc_skid
`default_nettype wire
